//--- verilog/crf_pkg.sv
package crf_pkg;

  // ----------------------------------------------------------------
  // sizes of the text fields
  // ----------------------------------------------------------------
  localparam int NAME_MAX = 16;           // command name characters held
  localparam int TEXT_MAX = 40;           // response text field width

  // ----------------------------------------------------------------
  // binary frame layout, byte offsets
  // ----------------------------------------------------------------
  localparam int OFS_SYNC0   = 0;
  localparam int OFS_SYNC1   = 1;
  localparam int OFS_SYNC2   = 2;
  localparam int OFS_HDRLEN  = 3;
  localparam int OFS_MSGID   = 4;
  localparam int OFS_TYPE    = 6;
  localparam int OFS_PORT    = 7;
  localparam int OFS_LEN     = 8;
  localparam int OFS_SEQ     = 10;
  localparam int OFS_IDLE    = 12;
  localparam int OFS_TSTAT   = 13;
  localparam int OFS_WEEK    = 14;
  localparam int OFS_MS      = 16;
  localparam int OFS_RXSTAT  = 20;
  localparam int OFS_RSVD    = 24;
  localparam int OFS_SWBUILD = 26;
  localparam int OFS_RESPID  = 28;
  localparam int OFS_TEXT    = 32;
  localparam int RESPID_BYTES = 4;
  localparam int CRC_BYTES    = 4;
  localparam int HEX_DIGITS   = 8;

  // ----------------------------------------------------------------
  // fixed byte values
  // ----------------------------------------------------------------
  localparam logic [7:0] SYNC0_VAL  = 8'haa;
  localparam logic [7:0] SYNC1_VAL  = 8'h44;
  localparam logic [7:0] SYNC2_VAL  = 8'h12;
  localparam logic [7:0] HDR_LEN    = 8'h1c;   // header is 28 bytes
  localparam logic [7:0] RESP_BIT   = 8'h80;   // bit 7 of message type
  localparam logic [7:0] CH_LT      = 8'h3c;   // '<'
  localparam logic [7:0] CH_HASH    = 8'h23;   // '#'
  localparam logic [7:0] CH_R       = 8'h52;   // 'R'
  localparam logic [7:0] CH_SEMI    = 8'h3b;   // ';'
  localparam logic [7:0] CH_QUOTE   = 8'h22;   // '"'
  localparam logic [7:0] CH_STAR    = 8'h2a;   // '*'
  localparam logic [7:0] CH_CR      = 8'h0d;
  localparam logic [7:0] CH_LF      = 8'h0a;
  localparam logic [7:0] CH_ZERO    = 8'h30;
  localparam logic [7:0] CH_A_LOW   = 8'h57;   // 'a' minus ten

  // ----------------------------------------------------------------
  // time status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] TS_UNKNOWN = 8'h14;   // 20
  localparam logic [7:0] TS_COARSE  = 8'h64;   // 100
  localparam logic [7:0] TS_FINE    = 8'ha0;   // 160
  localparam logic [7:0] TS_FINE_ST = 8'hb4;   // 180

  // ----------------------------------------------------------------
  // checksum
  // ----------------------------------------------------------------
  localparam logic [31:0] CRC_POLY  = 32'hedb88320;
  localparam logic [31:0] CRC_INIT  = 32'h00000000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CRF_FMT_ABBR,
    CRF_FMT_TEXT,
    CRF_FMT_BIN
  } crf_fmt_t;

  typedef struct packed {
    crf_fmt_t                     fmt;
    logic [15:0]                  msg_id;
    logic [7:0]                   port_id;
    logic [NAME_MAX-1:0][7:0]     name;
    logic [4:0]                   name_len;
    logic [31:0]                  response_identifier;
    logic [TEXT_MAX-1:0][7:0]     text;
    logic [5:0]                   text_len;
    logic [7:0]                   time_status;
    logic [15:0]                  week;
    logic [31:0]                  ms;
    logic [31:0]                  rx_status;
    logic [15:0]                  sw_build;
  } crf_cmd_t;

  typedef struct packed {
    logic [7:0] data;
    logic       first;
    logic       last;
  } crf_byte_t;

endpackage

//--- verilog/crf_crc32.sv
module crf_crc32 (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // control
  input  wire logic        clear,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  // result
  output logic      [31:0] crc
);

  // ----------------------------------------------------------------
  // one byte of the reflected crc
  // ----------------------------------------------------------------
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ crf_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // clear wins over a byte in the same cycle: a new frame starts clean
  always_ff @(posedge mclk) begin
    if (!rstn || clear) begin
      crc <= crf_pkg::CRC_INIT;
    end else if (en) begin
      crc <= crc_byte(crc, data);
    end
  end

endmodule // crf_crc32

//--- verilog/crf_framer.sv
// Function
// - a response is built for every command unless responses are switched off
// - the response uses the same encoding as the command
// - abbreviated reply is '<' then the response text, nothing more
// - text header names the command with 'R' appended
// - text body carries the response text in a 40 character field
// - binary frames open with sync bytes aa 44 12 then header length
// - header length byte at offset 3, 16-bit message id at offset 4
// - message type byte at offset 6 has bit 7 set
// - port identifier byte at offset 7
// - 16-bit body length at offset 8, checksum excluded
// - time status at offset 13 is a single byte
// - week at offset 14, milliseconds of week at offset 16
// - status word at 20, two reserved bytes, build number at 26
// - body starts at 28 with a four-byte response identifier
// - response text bytes follow from offset 32
// - time status codes 20, 100, 160, 180 as given
module crf_framer (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rstn,
  // port setting
  input  wire logic               port_protocol_setting_resp_en,
  // command in
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire crf_pkg::crf_cmd_t  cmd,
  // response byte stream out
  output logic                    tx_valid,
  input  wire logic               tx_ready,
  output crf_pkg::crf_byte_t      tx_byte
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // the trail state is skipped by the abbreviated form, which has no checksum
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BODY,
    ST_TRAIL
  } crf_state_t;

  // registers of the frame walk
  crf_state_t         state_reg;
  crf_pkg::crf_cmd_t  cmd_reg;
  logic [7:0]         pos_reg;
  logic               tx_valid_reg;
  crf_pkg::crf_byte_t tx_byte_reg;

  // ----------------------------------------------------------------
  // decode of the current position
  // ----------------------------------------------------------------
  logic [31:0]        crc;
  logic               adv;
  logic               accept;
  logic [7:0]         body_len;
  logic [7:0]         trail_len;
  logic [7:0]         body_byte;
  logic [7:0]         trail_byte;
  logic               crc_take;
  logic [7:0]         hdr_bytes [0:crf_pkg::OFS_TEXT-1];
  logic [15:0]        msg_len;
  logic [5:0]         tlen;
  logic [7:0]         p_text;
  logic               crc_en;

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  // the output register takes a new byte when empty or being drained
  assign adv       = !tx_valid_reg || tx_ready;
  assign cmd_ready = (state_reg == ST_IDLE);
  assign accept    = cmd_valid && cmd_ready;
  assign tx_valid  = tx_valid_reg;
  assign tx_byte   = tx_byte_reg;
  assign tlen      = cmd_reg.text_len;
  assign msg_len   = 16'(crf_pkg::RESPID_BYTES) + 16'(tlen);
  // only body bytes feed the sum, and only when they really move
  assign crc_en    = (state_reg == ST_BODY) && adv && crc_take;

  // ----------------------------------------------------------------
  // frame lengths per encoding
  // ----------------------------------------------------------------
  // body runs up to the checksum; trail is the checksum and any line end
  always_comb begin
    unique case (cmd_reg.fmt)
      crf_pkg::CRF_FMT_ABBR: begin
        body_len  = 8'(1 + tlen);
        trail_len = 8'h00;
      end
      crf_pkg::CRF_FMT_TEXT: begin
        body_len  = 8'(cmd_reg.name_len + tlen + 6);
        trail_len = 8'(crf_pkg::HEX_DIGITS + 2);
      end
      default: begin
        body_len  = 8'(crf_pkg::OFS_TEXT + tlen);
        trail_len = 8'(crf_pkg::CRC_BYTES);
      end
    endcase
  end

  // ----------------------------------------------------------------
  // binary header image, least significant byte first
  // ----------------------------------------------------------------
  // sequence, idle time and reserved bytes are not tracked and go out as zero
  always_comb begin
    for (int i = 0; i < crf_pkg::OFS_TEXT; i++) begin
      hdr_bytes[i] = 8'h00;                    // sequence, idle, reserved read zero
    end
    hdr_bytes[crf_pkg::OFS_SYNC0]  = crf_pkg::SYNC0_VAL;
    hdr_bytes[crf_pkg::OFS_SYNC1]  = crf_pkg::SYNC1_VAL;
    hdr_bytes[crf_pkg::OFS_SYNC2]  = crf_pkg::SYNC2_VAL;
    hdr_bytes[crf_pkg::OFS_HDRLEN] = crf_pkg::HDR_LEN;
    hdr_bytes[crf_pkg::OFS_TYPE]   = crf_pkg::RESP_BIT;
    hdr_bytes[crf_pkg::OFS_PORT]   = cmd_reg.port_id;
    hdr_bytes[crf_pkg::OFS_TSTAT]  = cmd_reg.time_status;
    // two-byte fields
    for (int k = 0; k < 2; k++) begin
      hdr_bytes[crf_pkg::OFS_MSGID + k]   = cmd_reg.msg_id[8*k +: 8];
      hdr_bytes[crf_pkg::OFS_LEN + k]     = msg_len[8*k +: 8];
      hdr_bytes[crf_pkg::OFS_WEEK + k]    = cmd_reg.week[8*k +: 8];
      hdr_bytes[crf_pkg::OFS_SWBUILD + k] = cmd_reg.sw_build[8*k +: 8];
    end
    // four-byte fields
    for (int k = 0; k < 4; k++) begin
      hdr_bytes[crf_pkg::OFS_MS + k]     = cmd_reg.ms[8*k +: 8];
      hdr_bytes[crf_pkg::OFS_RXSTAT + k] = cmd_reg.rx_status[8*k +: 8];
      hdr_bytes[crf_pkg::OFS_RESPID + k] =
        cmd_reg.response_identifier[8*k +: 8];
    end
  end

  // ----------------------------------------------------------------
  // byte at the current body position
  // ----------------------------------------------------------------
  // each encoding walks its own layout from position zero
  always_comb begin
    body_byte = 8'h00;
    crc_take  = 1'b0;
    p_text    = 8'h00;
    unique case (cmd_reg.fmt)
      crf_pkg::CRF_FMT_ABBR: begin
        // no checksum: the short form is for people at a terminal
        if (pos_reg == 8'h00) begin
          body_byte = crf_pkg::CH_LT;
        end else begin
          body_byte = cmd_reg.text[6'(pos_reg - 8'h01)];
        end
      end
      crf_pkg::CRF_FMT_TEXT: begin
        // checksum covers everything between the hash and the star
        crc_take = (pos_reg != 8'h00) && (pos_reg != 8'(body_len - 8'h01));
        p_text   = 8'(pos_reg - 8'(cmd_reg.name_len) - 8'h04);
        if (pos_reg == 8'h00) begin
          body_byte = crf_pkg::CH_HASH;
        end else if (pos_reg <= 8'(cmd_reg.name_len)) begin
          body_byte = cmd_reg.name[4'(pos_reg - 8'h01)];
        end else if (pos_reg == 8'(cmd_reg.name_len + 1)) begin
          body_byte = crf_pkg::CH_R;
        end else if (pos_reg == 8'(cmd_reg.name_len + 2)) begin
          body_byte = crf_pkg::CH_SEMI;
        end else if (pos_reg == 8'(cmd_reg.name_len + 3)) begin
          body_byte = crf_pkg::CH_QUOTE;
        end else if (p_text < 8'(tlen)) begin
          body_byte = cmd_reg.text[6'(p_text)];
        end else if (p_text == 8'(tlen)) begin
          body_byte = crf_pkg::CH_QUOTE;
        end else begin
          body_byte = crf_pkg::CH_STAR;
        end
      end
      default: begin
        // the binary sum covers every byte, sync bytes included
        crc_take = 1'b1;
        if (pos_reg < 8'(crf_pkg::OFS_TEXT)) begin
          body_byte = hdr_bytes[5'(pos_reg)];
        end else begin
          body_byte = cmd_reg.text[6'(pos_reg - 8'(crf_pkg::OFS_TEXT))];
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // trailer byte: binary crc or text hex checksum and line end
  // ----------------------------------------------------------------
  // hex digits go out most significant nibble first, in lower case
  always_comb begin
    logic [3:0] nib;
    nib        = 4'h0;
    trail_byte = 8'h00;
    if (cmd_reg.fmt == crf_pkg::CRF_FMT_BIN) begin
      trail_byte = crc[8*pos_reg[1:0] +: 8];
    end else if (pos_reg < 8'(crf_pkg::HEX_DIGITS)) begin
      nib        = crc[4*(3'h7 - pos_reg[2:0]) +: 4];
      trail_byte = (nib < 4'ha) ? (crf_pkg::CH_ZERO + 8'(nib)) : (crf_pkg::CH_A_LOW + 8'(nib));
    end else if (pos_reg == 8'(crf_pkg::HEX_DIGITS)) begin
      trail_byte = crf_pkg::CH_CR;
    end else begin
      trail_byte = crf_pkg::CH_LF;
    end
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // a dropped command is taken and forgotten at once, so ready never falls for it
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      pos_reg   <= 8'h00;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          pos_reg <= 8'h00;
          if (accept && port_protocol_setting_resp_en) begin
            state_reg <= ST_BODY;
          end
        end
        ST_BODY: begin
          if (adv) begin
            if (pos_reg == 8'(body_len - 8'h01)) begin
              pos_reg   <= 8'h00;
              state_reg <= (trail_len == 8'h00) ? ST_IDLE : ST_TRAIL;
            end else begin
              pos_reg <= pos_reg + 8'h01;
            end
          end
        end
        ST_TRAIL: begin
          if (adv) begin
            if (pos_reg == 8'(trail_len - 8'h01)) begin
              pos_reg   <= 8'h00;
              state_reg <= ST_IDLE;
            end else begin
              pos_reg <= pos_reg + 8'h01;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command latch
  // ----------------------------------------------------------------
  // latch the command; text and name lengths are clamped to their fields
  // over-long text is cut rather than refused, so every command still gets a reply while responses are on
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cmd_reg <= '0;
    end else if (accept) begin
      cmd_reg          <= cmd;
      cmd_reg.text_len <= (cmd.text_len > 6'(crf_pkg::TEXT_MAX)) ?
                          6'(crf_pkg::TEXT_MAX) : cmd.text_len;
      cmd_reg.name_len <= (cmd.name_len > 5'(crf_pkg::NAME_MAX)) ?
                          5'(crf_pkg::NAME_MAX) : cmd.name_len;
    end
  end

  // ----------------------------------------------------------------
  // output register
  // ----------------------------------------------------------------
  // valid flag; falls once the last byte has gone and nothing follows
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tx_valid_reg <= 1'b0;
    end else if (adv) begin
      tx_valid_reg <= (state_reg == ST_BODY) || (state_reg == ST_TRAIL);
    end
  end

  // byte and markers; held while the sink stalls so a slow host loses nothing
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tx_byte_reg <= '0;
    end else if (adv && (state_reg == ST_BODY)) begin
      tx_byte_reg.data  <= body_byte;
      tx_byte_reg.first <= (pos_reg == 8'h00);
      tx_byte_reg.last  <= (pos_reg == 8'(body_len - 8'h01)) && (trail_len == 8'h00);
    end else if (adv && (state_reg == ST_TRAIL)) begin
      tx_byte_reg.data  <= trail_byte;
      tx_byte_reg.first <= 1'b0;
      tx_byte_reg.last  <= (pos_reg == 8'(trail_len - 8'h01));
    end
  end

  // ----------------------------------------------------------------
  // checksum engine, restarted per accepted command
  // ----------------------------------------------------------------
  // cleared on dropped commands too, so a stale sum can never leak into a frame
  crf_crc32 u_crc (
    .mclk  (mclk),
    .rstn  (rstn),
    .clear (accept),
    .en    (crc_en),
    .data  (body_byte),
    .crc   (crc)
  );

endmodule // crf_framer

//--- testbench/crf_framer_checker.sv
module crf_framer_checker (
  // clock and reset
  input wire logic               mclk,
  input wire logic               rstn,
  // command side
  input wire logic               port_protocol_setting_resp_en,
  input wire logic               cmd_valid,
  input wire logic               cmd_ready,
  input wire crf_pkg::crf_cmd_t  cmd,
  // byte stream
  input wire logic               tx_valid,
  input wire logic               tx_ready,
  input wire crf_pkg::crf_byte_t tx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // ----
  // frame tracking
  // ----
  logic              take;
  logic              bin;
  crf_pkg::crf_fmt_t p_fmt, c_fmt;
  logic [5:0]        p_n, p_t, c_n, c_t;
  logic [6:0]        idx_reg, last_idx;
  logic [7:0]        lead;
  assign take = cmd_valid && cmd_ready;
  assign bin  = tx_valid && c_fmt == crf_pkg::CRF_FMT_BIN;
  // shape waits until the previous frame's last byte has left
  always_ff @(posedge mclk) begin
    if (take) begin
      p_fmt <= cmd.fmt;
      p_n   <= (cmd.name_len > 5'd16) ? 6'd16 : {1'b0, cmd.name_len};
      p_t   <= (cmd.text_len > 6'd40) ? 6'd40 : cmd.text_len;
    end
    if (!tx_valid || (tx_ready && tx_byte.last)) begin
      c_fmt <= p_fmt;
      c_n   <= p_n;
      c_t   <= p_t;
    end
  end
  // byte index within the frame on the wire
  always_ff @(posedge mclk) begin
    if (!rstn || (tx_valid && tx_ready && tx_byte.last)) idx_reg <= 7'h00;
    else if (tx_valid && tx_ready) idx_reg <= idx_reg + 7'h01;
  end
  always_comb begin
    case (c_fmt)
      crf_pkg::CRF_FMT_ABBR: begin
        last_idx = {1'b0, c_t};
        lead     = 8'h3c;
      end
      crf_pkg::CRF_FMT_TEXT: begin
        last_idx = 7'd15 + {1'b0, c_n} + {1'b0, c_t};
        lead     = 8'h23;
      end
      default: begin
        last_idx = 7'd35 + {1'b0, c_t};
        lead     = 8'haa;
      end
    endcase
  end

  reset_idle_a: assert property (disable iff (1'b0) !rstn |=> cmd_ready && !tx_valid)
    else $error("not idle after reset");
  hold_stall_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("byte changed while stalled");
  first_lat_a: assert property (take && port_protocol_setting_resp_en && !tx_valid
    |=> !cmd_ready ##1 (tx_valid && tx_byte.first)) else $error("response late");
  no_resp_a: assert property (take && !port_protocol_setting_resp_en
    |=> cmd_ready && !tx_valid ##1 !tx_valid) else $error("suppressed response sent");
  first_flag_a: assert property (tx_valid |-> tx_byte.first == (idx_reg == 7'h00))
    else $error("first flag misplaced");
  lead_byte_a: assert property (tx_valid && tx_byte.first |-> tx_byte.data == lead)
    else $error("wrong leading byte");
  bin_sync_a: assert property (bin && idx_reg inside {[1:3]} |-> tx_byte.data ==
    (idx_reg == 7'd1 ? 8'h44 : idx_reg == 7'd2 ? 8'h12 : 8'h1c)) else $error("bad sync");
  resp_bit_a: assert property (bin && idx_reg == 7'd6 |-> tx_byte.data[7])
    else $error("response bit clear");
  frame_len_a: assert property (tx_valid |-> tx_byte.last == (idx_reg == last_idx))
    else $error("frame length wrong");

  cover property (take && port_protocol_setting_resp_en && cmd.fmt == crf_pkg::CRF_FMT_BIN);
  cover property (take && !port_protocol_setting_resp_en);
  cover property (take && port_protocol_setting_resp_en && cmd.fmt == crf_pkg::CRF_FMT_TEXT);
  cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready && tx_byte.last);
endmodule // crf_framer_checker

bind crf_framer crf_framer_checker u_chk (.mclk(mclk), .rstn(rstn),
  .port_protocol_setting_resp_en(port_protocol_setting_resp_en), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd(cmd), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_byte(tx_byte));

//--- testbench/crf_host_model.sv
module crf_host_model (
  // clock
  input wire logic               mclk,
  // stall control
  input wire logic               slow,
  // stream from the device
  input wire logic               tx_valid,
  output logic                   tx_ready,
  input wire crf_pkg::crf_byte_t tx_byte,
  // byte taken, one cycle strobe
  output logic                   got,
  output crf_pkg::crf_byte_t     got_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  // a slow host drops ready at random, so stalls land anywhere in a frame
  always @(negedge mclk) tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
  // record each byte handed over
  always @(posedge mclk) begin
    got      <= tx_valid && tx_ready;
    got_byte <= tx_byte;
  end
endmodule // crf_host_model

//--- testbench/crf_framer_bench.sv
module crf_framer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic               mclk, rstn, resp_en, cmd_valid, cmd_ready, tx_valid, tx_ready;
  logic               slow, got;
  crf_pkg::crf_cmd_t  cmd, cc;
  crf_pkg::crf_byte_t tx_byte, got_byte;
  crf_pkg::crf_byte_t exp_q[$];
  logic [7:0]         bq[$];
  int                 err_total, samples_checked, cycles, s;
  logic [7:0]         ts_tab[4] = '{8'h14, 8'h64, 8'ha0, 8'hb4};

  crf_framer DUT (.mclk(mclk), .rstn(rstn), .port_protocol_setting_resp_en(resp_en),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_byte(tx_byte));
  crf_host_model u_host (.mclk(mclk), .slow(slow), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_byte(tx_byte), .got(got), .got_byte(got_byte));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ----
  // expected frames
  // ----
  function automatic logic [31:0] crc_b(logic [31:0] c, logic [7:0] d);
    c = c ^ {24'h0, d};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ crf_pkg::CRC_POLY : c >> 1;
    return c;
  endfunction
  function automatic logic [7:0] hexc(logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h57 + 8'(n);
  endfunction
  task automatic put(logic [31:0] v, int n);
    for (int i = 0; i < n; i++) bq.push_back(v[8*i +: 8]);
  endtask
  function automatic crf_pkg::crf_cmd_t mk(crf_pkg::crf_fmt_t f, int tl, logic [7:0] ts);
    crf_pkg::crf_cmd_t c;
    c = '0;
    c.fmt = f;
    c.msg_id = 16'($urandom);
    c.port_id = 8'($urandom);
    c.name[2:0] = {8'h47, 8'h4f, 8'h4c};
    c.name_len = 5'd3;
    c.response_identifier = $urandom;
    c.text_len = 6'(tl);
    for (int i = 0; i < tl; i++) c.text[i] = 8'h41 + 8'($urandom_range(25));
    if (tl == 2) c.text[1:0] = {8'h4b, 8'h4f};
    c.time_status = ts;
    c.week = 16'($urandom);
    c.ms = $urandom;
    c.rx_status = $urandom;
    c.sw_build = 16'($urandom);
    return c;
  endfunction

  // host side: note the expected frame when responses are on, then offer the whole command
  task automatic send(crf_pkg::crf_cmd_t c, logic en);
    logic [31:0]       crc;
    int                n;
    crf_pkg::crf_cmd_t w;
    w = c;
    crc = 32'h0;
    if (c.text_len > 6'd40) c.text_len = 6'd40;
    if (c.name_len > 5'd16) c.name_len = 5'd16;
    bq.delete();
    if (c.fmt == crf_pkg::CRF_FMT_ABBR) begin
      bq.push_back(crf_pkg::CH_LT);
      for (int i = 0; i < c.text_len; i++) bq.push_back(c.text[i]);
    end else if (c.fmt == crf_pkg::CRF_FMT_TEXT) begin
      for (int i = 0; i < c.name_len; i++) bq.push_back(c.name[i]);
      put(32'h223b52, 3);
      for (int i = 0; i < c.text_len; i++) bq.push_back(c.text[i]);
      bq.push_back(crf_pkg::CH_QUOTE);
      foreach (bq[i]) crc = crc_b(crc, bq[i]);
      bq.push_front(crf_pkg::CH_HASH);
      bq.push_back(crf_pkg::CH_STAR);
      for (int i = 7; i >= 0; i--) bq.push_back(hexc(crc[4*i +: 4]));
      put(32'h0a0d, 2);
    end else begin
      put(32'h1c1244aa, 4);
      put(32'(c.msg_id), 2);
      put({16'h0, c.port_id, 8'h80}, 2);
      put(32'(c.text_len) + 32'd4, 2);
      put(32'h0, 3);
      put(32'(c.time_status), 1);
      put(32'(c.week), 2);
      put(c.ms, 4);
      put(c.rx_status, 4);
      put(32'(c.sw_build) << 16, 4);
      put(c.response_identifier, 4);
      for (int i = 0; i < c.text_len; i++) bq.push_back(c.text[i]);
      foreach (bq[i]) crc = crc_b(crc, bq[i]);
      put(crc, 4);
    end
    if (en) foreach (bq[i]) exp_q.push_back('{bq[i], i == 0, i == bq.size() - 1});
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd = w;
    resp_en = en;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    if (n == 3000) begin
      err_total++;
      $display("BAD cmd_ready expected 1 seen %b", cmd_ready);
    end
    @(negedge mclk);
    cmd_valid = 1'b0;
  endtask

  task automatic drain(string name);
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    repeat (4) @(negedge mclk);
    if (exp_q.size() != 0) begin
      err_total++;
      $display("BAD frame_bytes expected %0d more seen 0", exp_q.size());
      exp_q.delete();
    end
    $display("test %s done, mismatches so far %0d", name, err_total);
  endtask

  task automatic check_byte(crf_pkg::crf_byte_t e, crf_pkg::crf_byte_t g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD tx_byte expected %h seen %h", e, g);
    end
  endtask

  // watcher: every byte the host takes is matched against the oldest note
  always @(negedge mclk) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) check_byte('1, got_byte);
      else check_byte(exp_q.pop_front(), got_byte);
    end
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard: the whole run needs well under two thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      test_done;
    end
  end

  initial begin
    rstn = 1'b0;
    resp_en = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    slow = 1'b0;
    s = $urandom(32'h98b8);
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    for (int f = 0; f < 3; f++) send(mk(crf_pkg::crf_fmt_t'(f), 2, 8'ha0), 1'b1);
    drain("formats");
    slow = 1'b1;
    for (int t = 0; t < 4; t++)
      send(mk(crf_pkg::CRF_FMT_BIN, t == 0 ? 40 : t == 1 ? 0 : 7 * t, ts_tab[t]), 1'b1);
    for (int f = 0; f < 2; f++) begin
      send(mk(crf_pkg::crf_fmt_t'(f), 40, 8'h14), 1'b1);
      send(mk(crf_pkg::crf_fmt_t'(f), 0, 8'h14), 1'b1);
    end
    // over-long text and name are cut to their fields, not refused
    for (int f = 1; f < 3; f++) begin
      cc = mk(crf_pkg::crf_fmt_t'(f), 40, 8'hb4);
      cc.text_len = 6'h3f;
      cc.name_len = 5'h1f;
      send(cc, 1'b1);
    end
    drain("stalled lengths");
    slow = 1'b0;
    send(mk(crf_pkg::CRF_FMT_TEXT, 5, 8'h64), 1'b0);
    send(mk(crf_pkg::CRF_FMT_ABBR, 2, 8'h64), 1'b1);
    drain("suppressed");
    test_done;
  end
endmodule // crf_framer_bench
